// ### common/smc_cfg.svh
// constants for the sleep mode controller
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH
`define SMC_KIND_IDLE       2'h0
`define SMC_KIND_NOISE      2'h1
`define SMC_KIND_PDOWN      2'h2
`define SMC_KIND_RSVD       2'h3
`define SMC_UNDERVOLT_SLEEP_OFF_BIT_POS        6
`define SMC_UNDERVOLT_SLEEP_UNLOCK_BIT_POS       5
`define SMC_UNDERVOLT_SLEEP_OFF_BIT_RST        1'h0
`define SMC_UNLOCK_CYC      3'h4
`define SMC_UNDERVOLT_SLEEP_OFF_BIT_DELAY_CYC  3'h3
`define SMC_UNDERVOLT_SLEEP_OFF_BIT_HOLD_CYC   3'h3
`define SMC_WAKE_STALL_CYC  3'h4
`define SMC_CNT_W           24
`endif

// ### common/smc_pkg.sv
// types for the sleep mode controller
package smc_pkg;
    typedef enum logic [1:0] {
        SMC_IDLE  = 2'h0,
        SMC_NOISE = 2'h1,
        SMC_PDOWN = 2'h2,
        SMC_RSVD  = 2'h3
    } smc_kind_t;
    typedef enum {SMC_RUN, SMC_SLEEP, SMC_STARTUP, SMC_STALL} smc_state_t;
endpackage : smc_pkg

// ### src/smc_undervolt_sleep_off_bit_timer.sv
// timed unlock and self-clearing window for the brown-out sleep-off bit
`timescale 1ns/100ps
`include "smc_cfg.svh"
module smc_undervolt_sleep_off_bit_timer (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic ce_i,
    input  wire logic wr_i,
    input  wire logic off_bit_i,
    input  wire logic unlock_bit_i,
    output logic      active_o
);
    logic [2:0] unlock_cnt;
    logic [2:0] arm_cnt;
    logic [2:0] hold_cnt;
    wire        unlock_req = wr_i && off_bit_i && unlock_bit_i;
    wire        set_req    = wr_i && off_bit_i && !unlock_bit_i && (unlock_cnt != 3'h0);

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            unlock_cnt <= 3'h0;
            arm_cnt    <= 3'h0;
            hold_cnt   <= 3'h0;
            active_o   <= `SMC_UNDERVOLT_SLEEP_OFF_BIT_RST;
        end else if (ce_i) begin
            // rewrite of unlock inside window does not extend it
            if (unlock_req && unlock_cnt == 3'h0)
                unlock_cnt <= `SMC_UNLOCK_CYC;
            else if (set_req)
                unlock_cnt <= 3'h0;
            else if (unlock_cnt != 3'h0)
                unlock_cnt <= unlock_cnt - 3'h1;
            if (set_req)
                arm_cnt <= `SMC_UNDERVOLT_SLEEP_OFF_BIT_DELAY_CYC;
            else if (arm_cnt != 3'h0)
                arm_cnt <= arm_cnt - 3'h1;
            if (arm_cnt == 3'h1) begin
                active_o <= 1'b1;
                hold_cnt <= `SMC_UNDERVOLT_SLEEP_OFF_BIT_HOLD_CYC;
            end else if (hold_cnt != 3'h0) begin
                hold_cnt <= hold_cnt - 3'h1;
                if (hold_cnt == 3'h1)
                    active_o <= 1'b0;
            end
        end
    end
endmodule : smc_undervolt_sleep_off_bit_timer

// ### src/smc_sleep_ctrl.sv
// sleep mode controller: clock gating, wake sources and start-up delay
// Overview of operation
// - sleep only when arm bit set and the sleep instruction executes.
// - kind 00 idle stops core and program clocks only.
// - kind 01 noise sleep also stops the peripheral clock.
// - kind 10 power-down stops oscillator and all generated clocks.
// - in idle any enabled interrupt wakes the device.
// - noise sleep wakes only from the listed converter-friendly sources.
// - power-down wakes only from the listed asynchronous sources.
// - external lines wake from deep modes only when level sensed.
// - interrupt wake stalls core four cycles after start-up, then handler.
// - register file and data memory are untouched by sleeping.
// - reset during sleep wakes and restarts from the reset vector.
// - enabled converter starts a conversion on idle or noise sleep entry.
// - power-down wake waits the fuse-selected start-up delay.
// - sleep-off bit is bit 6 of core control, resets to zero.
// - monitor off right after sleep entry, back on at wake.
// - with monitor off, wake delay is the full reset start-up time.
// - monitor enabled by fuse and not disabled stays on in sleep.
// - comparator auto-off in power-down unless it uses internal reference.
// - reference on when monitor, comparator or converter needs it.
// - converter restarted after being off does an extended conversion.
// - sleep-off set needs unlock write then set write within four cycles.
// - sleep-off active three cycles after set, clears three cycles later.
`timescale 1ns/100ps
`include "smc_cfg.svh"
module smc_sleep_ctrl (
    input  wire logic                   CLK_I,
    input  wire logic                   NRST_I,
    input  wire logic                   CE_I,
    input  wire logic                   SLEEP_ARM_BIT_I,
    input  wire smc_pkg::smc_kind_t     SLEEP_KIND_FIELD_I,
    input  wire logic                   SLEEP_INSTR_I,
    input  wire logic                   CORE_CTRL_WR_I,
    input  wire logic [7:0]             CORE_CTRL_WDATA_I,
    input  wire logic                   SYS_RESET_REQ_I,
    input  wire logic                   IRQ_PENDING_I,
    input  wire logic                   CONV_DONE_IRQ_I,
    input  wire logic                   WDOG_IRQ_I,
    input  wire logic                   TWO_WIRE_BUS_MATCH_I,
    input  wire logic                   NVM_READY_IRQ_I,
    input  wire logic                   EXT_IRQ_ZERO_I,
    input  wire logic                   EXT_IRQ_ONE_I,
    input  wire logic                   EXT_IRQ_ZERO_LEVEL_I,
    input  wire logic                   EXT_IRQ_ONE_LEVEL_I,
    input  wire logic                   PIN_CHANGE_IRQ_I,
    input  wire logic                   CONV_ENABLE_I,
    input  wire logic                   COMP_OFF_BIT_I,
    input  wire logic                   COMP_USES_REF_I,
    input  wire logic                   MONITOR_FUSE_EN_I,
    input  wire logic [`SMC_CNT_W-1:0]  CLOCK_SOURCE_FUSES_DELAY_I,
    input  wire logic [`SMC_CNT_W-1:0]  RESET_STARTUP_DELAY_I,
    output logic                        CORE_CLOCK_EN_O,
    output logic                        PROGRAM_MEMORY_CLOCK_EN_O,
    output logic                        PERIPHERAL_CLOCK_EN_O,
    output logic                        CONVERTER_CLOCK_EN_O,
    output logic                        OSC_EN_O,
    output logic                        CORE_STALL_O,
    output logic                        IRQ_TAKE_O,
    output logic                        RESET_VECTOR_O,
    output logic                        CONV_START_O,
    output logic                        CONV_EXTENDED_O,
    output logic                        MONITOR_EN_O,
    output logic                        COMP_EN_O,
    output logic                        VREF_EN_O,
    output logic                        UNDERVOLT_SLEEP_OFF_BIT_O,
    output logic                        SLEEPING_O
);
    import smc_pkg::*;

    smc_state_t                  state;
    smc_state_t                  next_state;
    smc_kind_t                   kind;
    logic [`SMC_CNT_W-1:0]       cnt;
    logic [`SMC_CNT_W-1:0]       next_cnt;
    logic                        mon_off;
    logic                        conv_was_on;
    logic                        undervolt_sleep_off_bit_active;

    // wake source filter shared by every deep mode decision
    function automatic logic wake_allowed(input smc_kind_t k,
                                          input logic irq, input logic cd,
                                          input logic wd, input logic tw,
                                          input logic nv, input logic e0,
                                          input logic e1, input logic l0,
                                          input logic l1, input logic pc);
        logic ext_lvl;
        ext_lvl = (e0 && l0) || (e1 && l1);
        case (k)
            SMC_IDLE:  wake_allowed = irq;
            SMC_NOISE: wake_allowed = cd || wd || tw || nv || ext_lvl || pc;
            SMC_PDOWN: wake_allowed = wd || tw || ext_lvl || pc;
            default:   wake_allowed = 1'b0;
        endcase
    endfunction : wake_allowed

    smc_undervolt_sleep_off_bit_timer u_undervolt_sleep_off_bit (
        .clk_i        (CLK_I),
        .nrst_i       (NRST_I),
        .ce_i         (CE_I),
        .wr_i         (CORE_CTRL_WR_I),
        .off_bit_i    (CORE_CTRL_WDATA_I[`SMC_UNDERVOLT_SLEEP_OFF_BIT_POS]),
        .unlock_bit_i (CORE_CTRL_WDATA_I[`SMC_UNDERVOLT_SLEEP_UNLOCK_BIT_POS]),
        .active_o     (undervolt_sleep_off_bit_active)
    );

    wire sleep_go    = SLEEP_INSTR_I && SLEEP_ARM_BIT_I
                       && (SLEEP_KIND_FIELD_I != SMC_RSVD);
    wire undervolt_sleep_off_bit_take   = undervolt_sleep_off_bit_active && (SLEEP_KIND_FIELD_I == SMC_PDOWN);
    wire wake        = wake_allowed(kind, IRQ_PENDING_I, CONV_DONE_IRQ_I, WDOG_IRQ_I,
                                    TWO_WIRE_BUS_MATCH_I, NVM_READY_IRQ_I,
                                    EXT_IRQ_ZERO_I, EXT_IRQ_ONE_I,
                                    EXT_IRQ_ZERO_LEVEL_I, EXT_IRQ_ONE_LEVEL_I,
                                    PIN_CHANGE_IRQ_I);
    // start-up length: full reset time when monitor was switched off
    wire [`SMC_CNT_W-1:0] startup_len = mon_off ? RESET_STARTUP_DELAY_I
                                                : CLOCK_SOURCE_FUSES_DELAY_I;
    wire in_sleep    = (state == SMC_SLEEP) || (state == SMC_STARTUP);
    wire in_pdown    = in_sleep && (kind == SMC_PDOWN);
    wire in_noise    = in_sleep && (kind == SMC_NOISE);
    wire next_conv_start = sleep_go && CONV_ENABLE_I && (state == SMC_RUN)
                           && (SLEEP_KIND_FIELD_I != SMC_PDOWN);
    wire comp_on     = !COMP_OFF_BIT_I && (!in_pdown || COMP_USES_REF_I);
    wire mon_on      = MONITOR_FUSE_EN_I && !(in_sleep && mon_off);
    wire next_vref   = mon_on || comp_on || CONV_ENABLE_I
                       || (COMP_USES_REF_I && !COMP_OFF_BIT_I);

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        case (state)
            SMC_RUN: begin
                if (sleep_go)
                    next_state = SMC_SLEEP;
            end
            SMC_SLEEP: begin
                if (wake) begin
                    // idle and noise keep the oscillator, so no start-up wait
                    if (kind == SMC_PDOWN) begin
                        next_state = SMC_STARTUP;
                        next_cnt   = startup_len;
                    end else begin
                        next_state = SMC_STALL;
                        next_cnt   = {{(`SMC_CNT_W-3){1'b0}}, `SMC_WAKE_STALL_CYC};
                    end
                end
            end
            SMC_STARTUP: begin
                if (cnt <= {{(`SMC_CNT_W-1){1'b0}}, 1'b1}) begin
                    next_state = SMC_STALL;
                    next_cnt   = {{(`SMC_CNT_W-3){1'b0}}, `SMC_WAKE_STALL_CYC};
                end else begin
                    next_cnt = cnt - {{(`SMC_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            SMC_STALL: begin
                if (cnt <= {{(`SMC_CNT_W-1){1'b0}}, 1'b1})
                    next_state = SMC_RUN;
                else
                    next_cnt = cnt - {{(`SMC_CNT_W-1){1'b0}}, 1'b1};
            end
            default: next_state = SMC_RUN;
        endcase
    end

    // SYS_RESET_REQ_I covers reset during sleep: state back to run from vector
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state   <= SMC_RUN;
            kind    <= SMC_IDLE;
            cnt     <= '0;
            mon_off <= 1'b0;
        end else if (CE_I) begin
            if (SYS_RESET_REQ_I && in_sleep) begin
                state   <= SMC_RUN;
                mon_off <= 1'b0;
            end else begin
                state <= next_state;
                cnt   <= next_cnt;
                if (state == SMC_RUN && sleep_go) begin
                    kind    <= SLEEP_KIND_FIELD_I;
                    mon_off <= undervolt_sleep_off_bit_take;
                end else if (next_state == SMC_RUN) begin
                    mon_off <= 1'b0;
                end
            end
        end
    end

    // all outputs registered; memories are never touched here
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            CORE_CLOCK_EN_O           <= 1'b1;
            PROGRAM_MEMORY_CLOCK_EN_O <= 1'b1;
            PERIPHERAL_CLOCK_EN_O     <= 1'b1;
            CONVERTER_CLOCK_EN_O      <= 1'b1;
            OSC_EN_O                  <= 1'b1;
            CORE_STALL_O              <= 1'b0;
            IRQ_TAKE_O                <= 1'b0;
            RESET_VECTOR_O            <= 1'b0;
            CONV_START_O              <= 1'b0;
            CONV_EXTENDED_O           <= 1'b0;
            conv_was_on               <= 1'b0;
            MONITOR_EN_O              <= 1'b0;
            COMP_EN_O                 <= 1'b0;
            VREF_EN_O                 <= 1'b0;
            UNDERVOLT_SLEEP_OFF_BIT_O <= `SMC_UNDERVOLT_SLEEP_OFF_BIT_RST;
            SLEEPING_O                <= 1'b0;
        end else if (CE_I) begin
            CORE_CLOCK_EN_O           <= !in_sleep;
            PROGRAM_MEMORY_CLOCK_EN_O <= !in_sleep;
            PERIPHERAL_CLOCK_EN_O     <= !(in_noise || in_pdown);
            CONVERTER_CLOCK_EN_O      <= !in_pdown;
            OSC_EN_O                  <= !(state == SMC_SLEEP && kind == SMC_PDOWN);
            CORE_STALL_O              <= (next_state == SMC_STALL);
            IRQ_TAKE_O                <= (state == SMC_STALL) && (next_state == SMC_RUN);
            RESET_VECTOR_O            <= SYS_RESET_REQ_I && in_sleep;
            CONV_START_O              <= next_conv_start;
            conv_was_on               <= CONV_ENABLE_I;
            // extended flag holds until the first conversion after the converter is enabled
            if (CONV_ENABLE_I && !conv_was_on)
                CONV_EXTENDED_O <= 1'b1;
            else if (CONV_START_O)
                CONV_EXTENDED_O <= 1'b0;
            MONITOR_EN_O              <= mon_on;
            COMP_EN_O                 <= comp_on;
            VREF_EN_O                 <= next_vref;
            UNDERVOLT_SLEEP_OFF_BIT_O <= undervolt_sleep_off_bit_active;
            SLEEPING_O                <= in_sleep;
        end
    end
endmodule : smc_sleep_ctrl

// ### verification/smc_sleep_ctrl_asserts.sv
// concurrent checks on the sleep controller ports
`timescale 1ns/100ps
module smc_sleep_ctrl_asserts (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic CE_I,
    input wire logic SLEEP_ARM_BIT_I,
    input wire logic SLEEP_INSTR_I,
    input wire logic CONV_ENABLE_I,
    input wire logic MONITOR_FUSE_EN_I,
    input wire logic CORE_CLOCK_EN_O,
    input wire logic PROGRAM_MEMORY_CLOCK_EN_O,
    input wire logic PERIPHERAL_CLOCK_EN_O,
    input wire logic CONVERTER_CLOCK_EN_O,
    input wire logic OSC_EN_O,
    input wire logic CORE_STALL_O,
    input wire logic IRQ_TAKE_O,
    input wire logic CONV_START_O,
    input wire logic MONITOR_EN_O,
    input wire logic VREF_EN_O,
    input wire logic UNDERVOLT_SLEEP_OFF_BIT_O,
    input wire logic SLEEPING_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence stall_run; CORE_STALL_O [*4]; endsequence
    sequence off_run; UNDERVOLT_SLEEP_OFF_BIT_O [*3]; endsequence
    a_noarm_nosleep: assert property (SLEEP_INSTR_I && !SLEEP_ARM_BIT_I && CE_I && !SLEEPING_O
        |-> ##2 !SLEEPING_O) else $error("sleep without arm bit");
    a_core_flash: assert property (CORE_CLOCK_EN_O == PROGRAM_MEMORY_CLOCK_EN_O)
        else $error("core and program clocks differ");
    a_periph_gate: assert property (!PERIPHERAL_CLOCK_EN_O |-> !CORE_CLOCK_EN_O)
        else $error("core runs with peripheral clock off");
    a_osc_gate: assert property (!OSC_EN_O |->
        !(CORE_CLOCK_EN_O || PERIPHERAL_CLOCK_EN_O || CONVERTER_CLOCK_EN_O))
        else $error("clock runs with oscillator off");
    a_stall_take: assert property ($rose(CORE_STALL_O) |->
        stall_run ##1 (!CORE_STALL_O && IRQ_TAKE_O)) else $error("stall length wrong");
    a_take_pulse: assert property (IRQ_TAKE_O |=> !IRQ_TAKE_O)
        else $error("handler entry longer than one cycle");
    a_conv_cause: assert property (CONV_START_O |-> $past(CONV_ENABLE_I))
        else $error("conversion start with converter off");
    a_off_window: assert property ($rose(UNDERVOLT_SLEEP_OFF_BIT_O) |->
        off_run ##1 !UNDERVOLT_SLEEP_OFF_BIT_O) else $error("sleep-off window length wrong");
    a_vref_need: assert property (MONITOR_EN_O && $past(MONITOR_EN_O) |-> VREF_EN_O)
        else $error("reference off while monitor on");
    // first edge after release still shows the reset value of the enable
    a_monitor_on: assert property (!SLEEPING_O && $past(!SLEEPING_O) && $past(NRST_I)
        && MONITOR_FUSE_EN_I |-> MONITOR_EN_O) else $error("monitor off while awake");
endmodule : smc_sleep_ctrl_asserts

bind smc_sleep_ctrl smc_sleep_ctrl_asserts smc_sleep_ctrl_asserts_i (.CLK_I, .NRST_I, .CE_I,
    .SLEEP_ARM_BIT_I, .SLEEP_INSTR_I, .CONV_ENABLE_I, .MONITOR_FUSE_EN_I, .CORE_CLOCK_EN_O,
    .PROGRAM_MEMORY_CLOCK_EN_O, .PERIPHERAL_CLOCK_EN_O, .CONVERTER_CLOCK_EN_O, .OSC_EN_O,
    .CORE_STALL_O, .IRQ_TAKE_O, .CONV_START_O, .MONITOR_EN_O, .VREF_EN_O,
    .UNDERVOLT_SLEEP_OFF_BIT_O, .SLEEPING_O);

// ### verification/smc_core_model.sv
// core and wake source model facing the sleep controller
`timescale 1ns/100ps
module smc_core_model (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic go_i,
    input  wire logic wake_i,
    input  wire logic take_i,
    output logic      instr_o,
    output logic      wake_o
);
    // combinational so the short sleep-off window is not missed
    assign instr_o = go_i;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wake_o <= 1'h0;
        end else if (take_i) begin
            wake_o <= 1'h0;
        end else if (wake_i) begin
            wake_o <= 1'h1;
        end
    end
endmodule : smc_core_model

// ### verification/tb_top.sv
// self-checking bench for the sleep controller
`timescale 1ns/100ps
`include "smc_cfg.svh"
module tb_top;
    import smc_pkg::*;
    logic CLK_I = 0, NRST_I = 0, CE_I, SLEEP_ARM_BIT_I = 0, SLEEP_INSTR_I, CORE_CTRL_WR_I = 0;
    smc_kind_t SLEEP_KIND_FIELD_I = SMC_IDLE;
    logic [7:0] CORE_CTRL_WDATA_I = 8'h00;
    logic SYS_RESET_REQ_I = 0, IRQ_PENDING_I, CONV_DONE_IRQ_I = 0, WDOG_IRQ_I = 0;
    logic TWO_WIRE_BUS_MATCH_I = 0, NVM_READY_IRQ_I = 0, EXT_IRQ_ZERO_I = 0, EXT_IRQ_ONE_I = 0;
    logic EXT_IRQ_ZERO_LEVEL_I = 0, EXT_IRQ_ONE_LEVEL_I = 0, PIN_CHANGE_IRQ_I, CONV_ENABLE_I = 0;
    logic COMP_OFF_BIT_I = 0, COMP_USES_REF_I = 0, MONITOR_FUSE_EN_I = 1;
    logic [`SMC_CNT_W-1:0] CLOCK_SOURCE_FUSES_DELAY_I = 24'h5, RESET_STARTUP_DELAY_I = 24'h9;
    logic CORE_CLOCK_EN_O, PROGRAM_MEMORY_CLOCK_EN_O, PERIPHERAL_CLOCK_EN_O, CONVERTER_CLOCK_EN_O;
    logic OSC_EN_O, CORE_STALL_O, IRQ_TAKE_O, RESET_VECTOR_O, CONV_START_O, CONV_EXTENDED_O;
    logic MONITOR_EN_O, COMP_EN_O, VREF_EN_O, UNDERVOLT_SLEEP_OFF_BIT_O, SLEEPING_O;
    logic go = 0, wake = 0, pend = 0;
    int errors = 0, check_count = 0, starts = 0, n;
    // idle, noise, power-down, reserved, unarmed: {kind, arm, sleep, core, periph, conv, osc}
    logic [7:0] rows [5] = '{8'h37, 8'h73, 8'hB0, 8'hEF, 8'h0F};
    assign CE_I = 1'h1;
    assign IRQ_PENDING_I = PIN_CHANGE_IRQ_I | pend;
    always #50 CLK_I = ~CLK_I;
    always @(posedge CLK_I) if (CONV_START_O === 1'h1) starts++;
    smc_sleep_ctrl smc_sleep_ctrl_i (.CLK_I, .NRST_I, .CE_I, .SLEEP_ARM_BIT_I, .SLEEP_KIND_FIELD_I,
        .SLEEP_INSTR_I, .CORE_CTRL_WR_I, .CORE_CTRL_WDATA_I, .SYS_RESET_REQ_I, .IRQ_PENDING_I,
        .CONV_DONE_IRQ_I, .WDOG_IRQ_I, .TWO_WIRE_BUS_MATCH_I, .NVM_READY_IRQ_I, .EXT_IRQ_ZERO_I,
        .EXT_IRQ_ONE_I, .EXT_IRQ_ZERO_LEVEL_I, .EXT_IRQ_ONE_LEVEL_I, .PIN_CHANGE_IRQ_I,
        .CONV_ENABLE_I, .COMP_OFF_BIT_I, .COMP_USES_REF_I, .MONITOR_FUSE_EN_I,
        .CLOCK_SOURCE_FUSES_DELAY_I, .RESET_STARTUP_DELAY_I, .CORE_CLOCK_EN_O,
        .PROGRAM_MEMORY_CLOCK_EN_O, .PERIPHERAL_CLOCK_EN_O, .CONVERTER_CLOCK_EN_O, .OSC_EN_O,
        .CORE_STALL_O, .IRQ_TAKE_O, .RESET_VECTOR_O, .CONV_START_O, .CONV_EXTENDED_O,
        .MONITOR_EN_O, .COMP_EN_O, .VREF_EN_O, .UNDERVOLT_SLEEP_OFF_BIT_O, .SLEEPING_O);
    smc_core_model smc_core_model_i (.clk_i(CLK_I), .nrst_i(NRST_I), .go_i(go), .wake_i(wake),
        .take_i(IRQ_TAKE_O), .instr_o(SLEEP_INSTR_I), .wake_o(PIN_CHANGE_IRQ_I));
    task chk(input string nm, input logic [4:0] e, input logic [4:0] s);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(posedge CLK_I);
    endtask : cyc
    task slp(input smc_kind_t k, input logic a);
        SLEEP_KIND_FIELD_I <= k;
        SLEEP_ARM_BIT_I <= a;
        go <= 1'h1;
        @(posedge CLK_I);
        go <= 1'h0;
        cyc(5);
        @(negedge CLK_I);
    endtask : slp
    task take_wait(output int c);
        c = 0;
        while (IRQ_TAKE_O !== 1'h1 && c < 300) begin
            @(negedge CLK_I);
            c++;
        end
        chk("irq_take", 5'h1, {4'h0, IRQ_TAKE_O});
        chk("awake", 5'h0, {4'h0, SLEEPING_O});
        @(posedge CLK_I);
    endtask : take_wait
    task test_done;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    initial begin
        cyc(20000);
        errors++;
        test_done();
    end
    initial begin
        cyc(10);
        NRST_I <= 1'h1;
        cyc(2);
        @(negedge CLK_I);
        chk("reset_gates", 5'h0F, {SLEEPING_O, CORE_CLOCK_EN_O, PERIPHERAL_CLOCK_EN_O,
            CONVERTER_CLOCK_EN_O, OSC_EN_O});
        chk("sleep_off_rst", 5'h0, {4'h0, UNDERVOLT_SLEEP_OFF_BIT_O});
        @(posedge CLK_I);
        CONV_ENABLE_I <= 1'h1;
        cyc(3);
        @(negedge CLK_I);
        chk("ext_conv_set", 5'h1, {4'h0, CONV_EXTENDED_O});
        foreach (rows[i]) begin
            @(posedge CLK_I);
            slp(smc_kind_t'(rows[i][7:6]), rows[i][5]);
            chk("gates", rows[i][4:0], {SLEEPING_O, CORE_CLOCK_EN_O, PERIPHERAL_CLOCK_EN_O,
                CONVERTER_CLOCK_EN_O, OSC_EN_O});
            if (rows[i][4]) begin
                @(posedge CLK_I);
                wake <= 1'h1;
                @(posedge CLK_I);
                wake <= 1'h0;
                take_wait(n);
            end
        end
        chk("conv_starts", 5'h2, 5'(starts));
        chk("ext_conv_clr", 5'h0, {4'h0, CONV_EXTENDED_O});
        // power-down ignores edge lines and non-listed sources
        CONV_ENABLE_I <= 1'h0;
        pend <= 1'h1;
        EXT_IRQ_ZERO_I <= 1'h1;
        CONV_DONE_IRQ_I <= 1'h1;
        NVM_READY_IRQ_I <= 1'h1;
        slp(SMC_PDOWN, 1'h1);
        cyc(20);
        @(negedge CLK_I);
        chk("pd_hold", 5'h1, {4'h0, SLEEPING_O});
        chk("comp_pd", 5'h0, {4'h0, COMP_EN_O});
        chk("vref_pd", 5'h1, {4'h0, VREF_EN_O});
        @(posedge CLK_I);
        EXT_IRQ_ZERO_LEVEL_I <= 1'h1;
        take_wait(n);
        chk("pd_delay", 5'h1, 5'(n >= 9 && n <= 16));
        EXT_IRQ_ZERO_I <= 1'h0;
        CONV_DONE_IRQ_I <= 1'h0;
        NVM_READY_IRQ_I <= 1'h0;
        EXT_IRQ_ONE_I <= 1'h1;
        slp(SMC_NOISE, 1'h1);
        cyc(10);
        @(negedge CLK_I);
        chk("noise_hold", 5'h1, {4'h0, SLEEPING_O});
        @(posedge CLK_I);
        WDOG_IRQ_I <= 1'h1;
        take_wait(n);
        chk("noise_fast", 5'h1, 5'(n <= 8));
        WDOG_IRQ_I <= 1'h0;
        pend <= 1'h0;
        EXT_IRQ_ONE_I <= 1'h0;
        COMP_USES_REF_I <= 1'h1;
        SLEEP_KIND_FIELD_I <= SMC_PDOWN;
        CORE_CTRL_WR_I <= 1'h1;
        CORE_CTRL_WDATA_I <= 8'h60;
        @(posedge CLK_I);
        CORE_CTRL_WDATA_I <= 8'h40;
        @(posedge CLK_I);
        CORE_CTRL_WR_I <= 1'h0;
        n = 0;
        while (UNDERVOLT_SLEEP_OFF_BIT_O !== 1'h1 && n < 10) begin
            @(negedge CLK_I);
            n++;
        end
        chk("sleep_off_on", 5'h1, {4'h0, UNDERVOLT_SLEEP_OFF_BIT_O});
        @(posedge CLK_I);
        slp(SMC_PDOWN, 1'h1);
        chk("monitor_off", 5'h0, {4'h0, MONITOR_EN_O});
        chk("comp_ref", 5'h3, {3'h0, COMP_EN_O, VREF_EN_O});
        @(posedge CLK_I);
        wake <= 1'h1;
        @(posedge CLK_I);
        wake <= 1'h0;
        take_wait(n);
        chk("full_delay", 5'h1, 5'(n >= 13 && n <= 20));
        @(negedge CLK_I);
        chk("monitor_back", 5'h1, {4'h0, MONITOR_EN_O});
        @(posedge CLK_I);
        slp(SMC_IDLE, 1'h1);
        @(posedge CLK_I);
        SYS_RESET_REQ_I <= 1'h1;
        n = 0;
        while (RESET_VECTOR_O !== 1'h1 && n < 20) begin
            @(negedge CLK_I);
            n++;
        end
        chk("reset_vector", 5'h2, {3'h0, RESET_VECTOR_O, IRQ_TAKE_O});
        @(posedge CLK_I);
        SYS_RESET_REQ_I <= 1'h0;
        cyc(5);
        @(negedge CLK_I);
        chk("reset_awake", 5'h0, {4'h0, SLEEPING_O});
        // second reset, pulled while asleep
        @(posedge CLK_I);
        slp(SMC_NOISE, 1'h1);
        chk("pre_reset", 5'h1, {4'h0, SLEEPING_O});
        @(posedge CLK_I);
        NRST_I <= 1'h0;
        cyc(2);
        NRST_I <= 1'h1;
        cyc(2);
        @(negedge CLK_I);
        chk("mid_reset", 5'h0F, {SLEEPING_O, CORE_CLOCK_EN_O, PERIPHERAL_CLOCK_EN_O,
            CONVERTER_CLOCK_EN_O, OSC_EN_O});
        test_done();
    end
endmodule : tb_top
